//--- src/pdbh_pkg.sv
// shared constants and state types for the parallel block handshake port
package pdbh_pkg;

    // block buffer
    localparam int unsigned PDBH_BUF_DEPTH = 15;
    localparam int unsigned PDBH_DATA_W = 8;

    // clock
    localparam int unsigned PDBH_CLK_PERIOD_NS = 10;

    // device: read acknowledge low time, least
    localparam int unsigned PDBH_T_ACK_LOW_NS = 200;
    // device: byte on pins before write-ready acknowledge falls, least
    localparam int unsigned PDBH_T_DATA_SETUP_NS = 18;
    // controller: byte on pins before request rises, least
    localparam int unsigned PDBH_T_HOST_SETUP_NS = 160;
    // controller: request low time between bytes, least
    localparam int unsigned PDBH_T_REQ_GAP_NS = 480;

    localparam logic [7:0] PDBH_ACK_LOW_CYC =
        8'((PDBH_T_ACK_LOW_NS + PDBH_CLK_PERIOD_NS - 1) / PDBH_CLK_PERIOD_NS);
    localparam logic [7:0] PDBH_DATA_SETUP_CYC =
        8'((PDBH_T_DATA_SETUP_NS + PDBH_CLK_PERIOD_NS - 1) / PDBH_CLK_PERIOD_NS);
    localparam logic [7:0] PDBH_HOST_SETUP_CYC =
        8'((PDBH_T_HOST_SETUP_NS + PDBH_CLK_PERIOD_NS - 1) / PDBH_CLK_PERIOD_NS);
    localparam logic [7:0] PDBH_REQ_GAP_CYC =
        8'((PDBH_T_REQ_GAP_NS + PDBH_CLK_PERIOD_NS - 1) / PDBH_CLK_PERIOD_NS);

    // idle levels of the link after reset
    localparam logic PDBH_ACK_IDLE = 1'b1;
    localparam logic PDBH_EOB_RESET = 1'b0;
    localparam logic [7:0] PDBH_BUS_PULL = 8'hFF;

    typedef enum logic [3:0] {
        DEV_IDLE = 4'b0000,
        DEV_FILL = 4'b0001,
        DEV_READY = 4'b0010,
        DEV_DEC_ACK = 4'b0011,
        DEV_DEC_REL = 4'b0100,
        DEV_ENC_SETUP = 4'b0101,
        DEV_ENC_ACK = 4'b0110,
        DEV_END = 4'b0111,
        DEV_DRAIN = 4'b1000
    } pdbh_dev_state_t;

    typedef enum logic [2:0] {
        HOST_WAIT = 3'b000,
        HOST_SETUP = 3'b001,
        HOST_REQ = 3'b010,
        HOST_HOLD = 3'b011,
        HOST_REL = 3'b100
    } pdbh_host_state_t;

endpackage

//--- src/pdbh_if.sv
// link between controller and device: handshake lines and shared byte pins
`timescale 1ns/1ps
interface pdbh_if;
    import pdbh_pkg::*;

    logic transfer_request;
    logic read_acknowledge_n;
    logic write_ready_acknowledge_n;
    logic end_of_block_n;
    logic [7:0] host_data_out;
    logic host_data_oe_n;
    logic [7:0] dev_data_out;
    logic dev_data_oe_n;
    logic [7:0] parallel_data_byte;

    // resolved pin level; undriven pins read as pulled high
    assign parallel_data_byte = !host_data_oe_n ? host_data_out :
                                !dev_data_oe_n ? dev_data_out : PDBH_BUS_PULL;

    modport device (
        input transfer_request,
        input parallel_data_byte,
        output read_acknowledge_n,
        output write_ready_acknowledge_n,
        output end_of_block_n,
        output dev_data_out,
        output dev_data_oe_n
    );

    modport host (
        output transfer_request,
        output host_data_out,
        output host_data_oe_n,
        input read_acknowledge_n,
        input write_ready_acknowledge_n,
        input end_of_block_n,
        input parallel_data_byte
    );
endinterface

//--- src/pdbh_sync.sv
// two-flop synchroniser with edge detection for one asynchronous line
`timescale 1ns/1ps
module pdbh_sync #(
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // line
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic stable_q;
    logic prev_q;

    // meta_q feeds stable_q only
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= INIT;
            stable_q <= INIT;
            prev_q <= INIT;
        end else begin
            meta_q <= async_in;
            stable_q <= meta_q;
            prev_q <= stable_q;
        end
    end

    assign level = stable_q;
    assign rise = stable_q & ~prev_q;
    assign fall = ~stable_q & prev_q;
endmodule // pdbh_sync

//--- src/pdbh_device.sv
// device end: byte handshake on the link and the block buffer behind it
`timescale 1ns/1ps
// Contract
// R1 - controller waits for flag high first
// R2 - controller raises request per decode byte
// R3 - device samples byte, drops read acknowledge
// R4 - controller drops request after acknowledge high
// R5 - each byte gets its own request cycle
// R6 - device drops flag after full block
// R7 - controller drops request, awaits flag rise
// R8 - block buffer depth is a parameter
// R9 - encode flag high means data ready
// R10 - encode request accepts exactly one byte
// R11 - byte on pins before write acknowledge
// R12 - write acknowledge rises after request drops
// R13 - controller responds well within ten ms
// R14 - buffer survives one long controller stall
// R15 - request synchronised, edge drives handshake
module pdbh_device
    import pdbh_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = PDBH_BUF_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link to the controller
    pdbh_if.device link,
    // mode, taken between blocks
    input wire logic mode_encode,
    // decoded bytes to the core
    output logic dec_valid,
    input wire logic dec_ready,
    output logic [7:0] dec_data,
    // bytes from the encoder core
    input wire logic enc_valid,
    output logic enc_ready,
    input wire logic [7:0] enc_data,
    // status
    output logic block_open
);
    localparam int IW = $clog2(BUF_DEPTH + 1);
    localparam logic [IW-1:0] LAST_IDX = IW'(BUF_DEPTH - 1);

    pdbh_dev_state_t state_q;
    pdbh_dev_state_t state_d;
    logic mode_q;
    logic [IW-1:0] idx_q;
    logic [7:0] tmr_q;
    logic [7:0] buf_q [BUF_DEPTH];
    logic [7:0] dout_q;
    logic dout_oe_n_q;
    logic rack_n_q;
    logic wack_n_q;
    logic eob_n_q;
    logic req_level;
    logic req_rise;
    logic last;
    logic enc_fire;
    logic dec_fire;
    logic take_req;
    logic advance;
    logic cap_link;

    // flag high while the block is open to the controller
    function automatic logic in_block(input pdbh_dev_state_t s);
        in_block = (s == DEV_READY) || (s == DEV_DEC_ACK) || (s == DEV_DEC_REL) ||
                   (s == DEV_ENC_SETUP) || (s == DEV_ENC_ACK);
    endfunction

    pdbh_sync #(
        .INIT(1'b0)
    ) u_req_sync (
        .clk(clk),
        .reset(reset),
        .async_in(link.transfer_request),
        .level(req_level),
        .rise(req_rise),
        .fall()
    ); // R15

    assign last = (idx_q == LAST_IDX);
    assign enc_ready = (state_q == DEV_FILL);
    assign dec_valid = (state_q == DEV_DRAIN);
    assign enc_fire = enc_valid && enc_ready;
    assign dec_fire = dec_valid && dec_ready;
    assign dec_data = buf_q[idx_q];
    assign block_open = eob_n_q;
    // a new byte starts only on a fresh rising edge of the request
    assign take_req = (state_q == DEV_READY) && req_rise; // R5 R15
    assign cap_link = take_req && !mode_q;
    assign advance = enc_fire || dec_fire ||
                     ((state_q == DEV_DEC_REL) && !req_level) ||
                     ((state_q == DEV_ENC_ACK) && !req_level);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DEV_IDLE: begin
                state_d = mode_encode ? DEV_FILL : DEV_READY;
            end
            DEV_FILL: begin
                if (enc_fire && last) begin
                    state_d = DEV_READY; // R9
                end
            end
            DEV_READY: begin
                if (take_req) begin
                    state_d = mode_q ? DEV_ENC_SETUP : DEV_DEC_ACK;
                end
            end
            DEV_DEC_ACK: begin
                if (tmr_q == 8'h00) begin
                    state_d = DEV_DEC_REL;
                end
            end
            DEV_DEC_REL: begin
                // wait for the controller to drop its request
                if (!req_level) begin
                    state_d = last ? DEV_END : DEV_READY; // R6
                end
            end
            DEV_ENC_SETUP: begin
                if (tmr_q == 8'h00) begin
                    state_d = DEV_ENC_ACK; // R11
                end
            end
            DEV_ENC_ACK: begin
                if (!req_level) begin
                    state_d = last ? DEV_END : DEV_READY; // R6 R12
                end
            end
            DEV_END: begin
                // flag stays low until the request is down, then refill or empty
                if (!req_level) begin
                    state_d = mode_q ? DEV_IDLE : DEV_DRAIN;
                end
            end
            DEV_DRAIN: begin
                if (dec_fire && last) begin
                    state_d = DEV_IDLE;
                end
            end
            default: begin
                state_d = DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= DEV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // mode only changes between blocks, never mid-block
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= 1'b0;
        end else if (state_q == DEV_IDLE) begin
            mode_q <= mode_encode;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            idx_q <= '0;
        end else if (state_q == DEV_IDLE) begin
            idx_q <= '0;
        end else if (advance) begin
            idx_q <= last ? '0 : idx_q + IW'(1); // R8
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_q <= 8'h00;
        end else if (take_req) begin
            tmr_q <= mode_q ? PDBH_DATA_SETUP_CYC - 8'h01 : PDBH_ACK_LOW_CYC - 8'h01;
        end else if (tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
        end
    end

    // a whole block sits in the buffer, so a stalled controller loses nothing
    generate
        for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
            always_ff @(posedge clk) begin
                if (reset) begin
                    buf_q[i] <= 8'h00;
                end else if (idx_q == IW'(i)) begin
                    if (cap_link) begin
                        buf_q[i] <= link.parallel_data_byte; // R3 R14
                    end else if (enc_fire) begin
                        buf_q[i] <= enc_data; // R14
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            dout_q <= 8'h00;
        end else if (take_req && mode_q) begin
            dout_q <= buf_q[idx_q]; // R10 R11
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dout_oe_n_q <= 1'b1;
        end else begin
            dout_oe_n_q <= !((state_d == DEV_ENC_SETUP) || (state_d == DEV_ENC_ACK)); // R11
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rack_n_q <= PDBH_ACK_IDLE;
            wack_n_q <= PDBH_ACK_IDLE;
        end else begin
            rack_n_q <= (state_d != DEV_DEC_ACK); // R3
            wack_n_q <= (state_d != DEV_ENC_ACK); // R11 R12
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            eob_n_q <= PDBH_EOB_RESET;
        end else begin
            eob_n_q <= in_block(state_d); // R6 R9
        end
    end

    assign link.read_acknowledge_n = rack_n_q;
    assign link.write_ready_acknowledge_n = wack_n_q;
    assign link.end_of_block_n = eob_n_q;
    assign link.dev_data_out = dout_q;
    assign link.dev_data_oe_n = dout_oe_n_q;
endmodule // pdbh_device

//--- src/pdbh_host.sv
// controller end: sends or fetches bytes one handshake at a time
`timescale 1ns/1ps
module pdbh_host
    import pdbh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link to the device
    pdbh_if.host link,
    // direction: 1 fetches encoded bytes
    input wire logic mode_encode,
    // bytes to send while decoding
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // bytes fetched while encoding
    output logic rx_valid,
    output logic [7:0] rx_data
);
    pdbh_host_state_t state_q;
    logic [7:0] tmr_q;
    logic req_q;
    logic [7:0] dout_q;
    logic dout_oe_n_q;
    logic rx_valid_q;
    logic [7:0] rx_data_q;
    logic eob_hi;
    logic rack_hi;
    logic wack_hi;

    pdbh_sync #(.INIT(1'b0)) u_eob_sync (
        .clk(clk), .reset(reset), .async_in(link.end_of_block_n),
        .level(eob_hi), .rise(), .fall()
    );
    pdbh_sync #(.INIT(1'b1)) u_rack_sync (
        .clk(clk), .reset(reset), .async_in(link.read_acknowledge_n),
        .level(rack_hi), .rise(), .fall()
    );
    pdbh_sync #(.INIT(1'b1)) u_wack_sync (
        .clk(clk), .reset(reset), .async_in(link.write_ready_acknowledge_n),
        .level(wack_hi), .rise(), .fall()
    );

    // a byte only starts while the flag is high
    assign tx_ready = (state_q == HOST_WAIT) && eob_hi && !mode_encode; // R1 R7

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= HOST_WAIT;
            tmr_q <= 8'h00;
            req_q <= 1'b0;
        end else begin
            if (tmr_q != 8'h00) begin
                tmr_q <= tmr_q - 8'h01;
            end
            unique case (state_q)
                HOST_WAIT: begin
                    if (eob_hi && mode_encode) begin
                        req_q <= 1'b1; // R10 R13
                        state_q <= HOST_REQ;
                    end else if (tx_valid && tx_ready) begin
                        tmr_q <= PDBH_HOST_SETUP_CYC;
                        state_q <= HOST_SETUP;
                    end
                end
                HOST_SETUP: begin
                    if (tmr_q == 8'h00) begin
                        req_q <= 1'b1; // R2
                        state_q <= HOST_REQ;
                    end
                end
                HOST_REQ: begin
                    if (mode_encode ? !wack_hi : !rack_hi) begin
                        req_q <= !mode_encode;
                        state_q <= mode_encode ? HOST_REL : HOST_HOLD;
                        tmr_q <= PDBH_REQ_GAP_CYC;
                    end
                end
                HOST_HOLD: begin
                    if (rack_hi) begin
                        req_q <= 1'b0; // R4
                        tmr_q <= PDBH_REQ_GAP_CYC;
                        state_q <= HOST_REL;
                    end
                end
                HOST_REL: begin
                    // the gap lets a falling flag reach us before the next byte
                    if (tmr_q == 8'h00 && wack_hi && rack_hi) begin
                        state_q <= HOST_WAIT; // R5 R7
                    end
                end
                default: begin
                    state_q <= HOST_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dout_q <= 8'h00;
            dout_oe_n_q <= 1'b1;
        end else if (tx_valid && tx_ready) begin
            dout_q <= tx_data;
            dout_oe_n_q <= 1'b0;
        end else if (state_q == HOST_HOLD && rack_hi) begin
            dout_oe_n_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else begin
            rx_valid_q <= (state_q == HOST_REQ) && mode_encode && !wack_hi;
            if ((state_q == HOST_REQ) && mode_encode && !wack_hi) begin
                rx_data_q <= link.parallel_data_byte;
            end
        end
    end

    assign rx_valid = rx_valid_q;
    assign rx_data = rx_data_q;
    assign link.transfer_request = req_q;
    assign link.host_data_out = dout_q;
    assign link.host_data_oe_n = dout_oe_n_q;
endmodule // pdbh_host

//--- sim/pdbh_checker.sv
// link checker: handshake timing and pin ownership between the two ends
`timescale 1ns/1ps
module pdbh_checker
    import pdbh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // handshake lines
    input wire logic transfer_request,
    input wire logic read_acknowledge_n,
    input wire logic write_ready_acknowledge_n,
    input wire logic end_of_block_n,
    // byte pins
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic [7:0] parallel_data_byte
);
    // counts sampled low cycles of the read acknowledge
    logic [7:0] rack_low_q;

    always_ff @(posedge clk) begin
        if (reset || read_acknowledge_n) begin
            rack_low_q <= 8'h00;
        end else begin
            rack_low_q <= rack_low_q + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // host driving the pins marks a decode byte
    sequence dec_req_s;
        $rose(transfer_request) && end_of_block_n && !host_data_oe_n;
    endsequence
    sequence enc_req_s;
        $rose(transfer_request) && end_of_block_n && host_data_oe_n;
    endsequence
    sequence rack_fall_s;
        $fell(read_acknowledge_n);
    endsequence
    sequence wack_fall_s;
        $fell(write_ready_acknowledge_n);
    endsequence

    dec_answer_a: assert property (dec_req_s |-> ##[1:6] rack_fall_s)
        else $error("read acknowledge missing after request");
    rack_cause_a: assert property (rack_fall_s |-> transfer_request && end_of_block_n)
        else $error("read acknowledge without open block request");
    ack_width_a: assert property ($rose(read_acknowledge_n)
        |-> rack_low_q == PDBH_ACK_LOW_CYC)
        else $error("read acknowledge low time wrong");
    enc_answer_a: assert property (enc_req_s |-> ##[2:8] wack_fall_s)
        else $error("write acknowledge missing after request");
    wack_setup_a: assert property (wack_fall_s |-> !dev_data_oe_n && !$past(dev_data_oe_n))
        else $error("write acknowledge before byte on pins");
    wack_data_a: assert property (!write_ready_acknowledge_n
        && !$past(write_ready_acknowledge_n) |-> $stable(parallel_data_byte))
        else $error("byte changed under write acknowledge");
    wack_hold_a: assert property (!write_ready_acknowledge_n && transfer_request
        |=> !write_ready_acknowledge_n)
        else $error("write acknowledge released under request");
    wack_release_a: assert property ($rose(write_ready_acknowledge_n)
        |-> !transfer_request && !$past(transfer_request))
        else $error("write acknowledge released before request drop");
    one_driver_a: assert property (!(!host_data_oe_n && !dev_data_oe_n))
        else $error("both ends drive the byte pins");
    flag_fall_a: assert property ($fell(end_of_block_n) |-> read_acknowledge_n)
        else $error("block end flagged mid byte");
endmodule // pdbh_checker

//--- sim/tb_top.sv
// testbench: controller and device ends joined, decode and encode blocks
`timescale 1ns/1ps
module tb_top;
    import pdbh_pkg::*;
    localparam int unsigned DEPTH = 15;
    logic clk, reset, mode_encode, dec_ready, enc_valid, tx_valid;
    logic [7:0] enc_data, tx_data, dec_data, rx_data;
    logic dec_valid, enc_ready, block_open, tx_ready, rx_valid;
    int fail_count = 0;
    int samples_checked = 0;
    logic [7:0] wire_q[$];

    pdbh_if link_i();
    pdbh_device #(.BUF_DEPTH(DEPTH)) pdbh_device_i (.clk(clk), .reset(reset), .link(link_i),
        .mode_encode(mode_encode), .dec_valid(dec_valid), .dec_ready(dec_ready),
        .dec_data(dec_data), .enc_valid(enc_valid), .enc_ready(enc_ready),
        .enc_data(enc_data), .block_open(block_open));
    pdbh_host pdbh_host_i (.clk(clk), .reset(reset), .link(link_i),
        .mode_encode(mode_encode), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data));
    pdbh_checker pdbh_checker_i (.clk(clk), .reset(reset),
        .transfer_request(link_i.transfer_request),
        .read_acknowledge_n(link_i.read_acknowledge_n),
        .write_ready_acknowledge_n(link_i.write_ready_acknowledge_n),
        .end_of_block_n(link_i.end_of_block_n), .host_data_oe_n(link_i.host_data_oe_n),
        .dev_data_oe_n(link_i.dev_data_oe_n), .parallel_data_byte(link_i.parallel_data_byte));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pin bytes as seen when either acknowledge falls, independent of both ends
    always @(negedge link_i.read_acknowledge_n) begin
        if (!reset) begin
            wire_q.push_back(link_i.parallel_data_byte);
        end
    end
    always @(negedge link_i.write_ready_acknowledge_n) begin
        if (!reset) begin
            wire_q.push_back(link_i.parallel_data_byte);
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic enc);
        mode_encode = enc;
        reset = 1'b1;
        step(3);
        check({link_i.read_acknowledge_n, link_i.write_ready_acknowledge_n,
            link_i.end_of_block_n, link_i.host_data_oe_n, link_i.dev_data_oe_n,
            link_i.transfer_request, 2'b00}, 8'hD8);
        reset = 1'b0;
        wire_q.delete();
        step(2);
    endtask

    // bounded wait for the block flag to reach a level
    task automatic wait_flag(input logic lvl);
        int n;
        n = 0;
        while (link_i.end_of_block_n !== lvl && n < 5000) begin
            step(1);
            n++;
        end
        check({6'h00, block_open, link_i.end_of_block_n}, {6'h00, lvl, lvl});
    endtask

    task automatic check_wire(input logic [7:0] base);
        check(8'(wire_q.size()), 8'(DEPTH));
        for (int i = 0; i < DEPTH && i < wire_q.size(); i++) begin
            check(wire_q[i], base + 8'(i));
        end
        wire_q.delete();
    endtask

    // decode: two blocks back to back, the core stalling before draining each
    task automatic t_decode();
        int n;
        do_reset(1'b0);
        for (int b = 0; b < 2; b++) begin
            wait_flag(1'b1);
            tx_valid = 1'b1;
            for (int i = 0; i < DEPTH; i++) begin
                tx_data = 8'h10 + 8'(b * 8'h40) + 8'(i);
                n = 0;
                while (tx_ready !== 1'b1 && n < 5000) begin
                    step(1);
                    n++;
                end
                check({7'h00, tx_ready}, 8'h01);
                step(1);
            end
            tx_valid = 1'b0;
            wait_flag(1'b0);
            check_wire(8'h10 + 8'(b * 8'h40));
            step(100);
            check({7'h00, link_i.end_of_block_n}, 8'h00);
            dec_ready = 1'b1;
            for (int i = 0; i < DEPTH; i++) begin
                n = 0;
                while (dec_valid !== 1'b1 && n < 100) begin
                    step(1);
                    n++;
                end
                check({7'h00, dec_valid}, 8'h01);
                check(dec_data, 8'h10 + 8'(b * 8'h40) + 8'(i));
                step(1);
            end
            dec_ready = 1'b0;
        end
        wait_flag(1'b1);
        $display("decode test done");
    endtask

    // encode: fill the block, flag stays low until full, host fetches every byte
    task automatic t_encode();
        int n;
        do_reset(1'b1);
        for (int b = 0; b < 2; b++) begin
            enc_valid = 1'b1;
            for (int i = 0; i < DEPTH; i++) begin
                enc_data = 8'hC0 - 8'(b * 8'h20) + 8'(i);
                n = 0;
                while (enc_ready !== 1'b1 && n < 5000) begin
                    step(1);
                    n++;
                end
                check({7'h00, enc_ready}, 8'h01);
                check({7'h00, link_i.end_of_block_n}, 8'h00);
                step(1);
            end
            enc_valid = 1'b0;
            wait_flag(1'b1);
            for (int i = 0; i < DEPTH; i++) begin
                n = 0;
                while (rx_valid !== 1'b1 && n < 2000) begin
                    step(1);
                    n++;
                end
                check({7'h00, rx_valid}, 8'h01);
                check(rx_data, 8'hC0 - 8'(b * 8'h20) + 8'(i));
                step(1);
            end
            wait_flag(1'b0);
            check_wire(8'hC0 - 8'(b * 8'h20));
        end
        $display("encode test done");
    endtask

    initial begin
        reset = 1'b1;
        mode_encode = 1'b0;
        dec_ready = 1'b0;
        enc_valid = 1'b0;
        enc_data = 8'h00;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        t_decode();
        t_encode();
        tally_and_finish();
    end

    // both tests need well under ten thousand cycles
    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule // tb_top
